// >>> include/lsp_pkg.sv
// package for the lcd-shared io port: register map, reset values, carriers
package lsp_pkg;
  localparam int unsigned LSP_ADDR_W = 2;
  localparam int unsigned LSP_DATA_W = 8;
  // register indices (byte-wide plain port, one register per address)
  localparam logic [1:0] LSP_ADDR_PIN_VALUE = 2'h0;
  localparam logic [1:0] LSP_ADDR_OUT_LATCH = 2'h1;
  localparam logic [1:0] LSP_ADDR_DIRECTION = 2'h2;
  localparam logic [1:0] LSP_ADDR_SEG_ENABLE = 2'h3;
  // values after reset: all inputs, no segments
  localparam logic [7:0] LSP_RESET_LATCH = 8'h00;
  localparam logic [7:0] LSP_RESET_DIR = 8'hff;
  localparam logic [7:0] LSP_RESET_SEG = 8'h00;
  // segment numbering of the shared pads
  localparam int unsigned LSP_SEG_BASE = 32;
  localparam int unsigned LSP_SEG_TOP = 39;
  // register bus request carrier
  typedef struct packed {
    logic [1:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } lsp_bus_req_t;
  // pad drive carrier, one bit per pin
  typedef struct packed {
    logic [7:0] dout;
    logic [7:0] oe;
    logic [7:0] seg_sel;
  } lsp_pad_t;
endpackage : lsp_pkg

// >>> hdl/lsp_sync.sv
// two-flop synchroniser for the pad inputs
`timescale 1ns/1ns
module lsp_sync #(
  parameter int unsigned WIDTH = 8
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  // first stage, read only by the second stage
  logic [WIDTH-1:0] meta_reg;

  initial begin
    if (WIDTH < 1) begin
      $error("lsp_sync: WIDTH must be at least 1");
    end
  end

  // both stages frozen while clock enable is low
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else if (clk_en) begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule : lsp_sync

// >>> hdl/lsp_port.sv
// eight-bit general io port whose pads are shared with lcd segments 32..39
`timescale 1ns/1ns
// Summary of operation
// - output pin drives latch bit when segment off
// - direction set: schmitt input read as pin value
// - segment enabled: segment owns pad, direction ignored
// - pins 0..3 carry segments 32..35 ascending
// - pins 4..7 carry segments 39..36 reversed
// - io function only while segment enable clear
module lsp_port #(
  parameter int unsigned PIN_COUNT = 8
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire lsp_pkg::lsp_bus_req_t bus_req,
  output logic [7:0] bus_rdata,
  input wire logic [7:0] schmitt_input,
  input wire logic [7:0] lcd_segment_in,
  output logic [7:0] digital_output,
  output logic [7:0] digital_output_en,
  output logic [7:0] analog_segment_output,
  output logic [7:0] analog_segment_sel
);
  import lsp_pkg::*;

  // software-visible registers
  logic [7:0] port_output_latch_reg;
  logic [7:0] port_direction_reg;
  logic [7:0] segment_enable_upper_reg;
  // pad level after synchronising
  logic [7:0] pin_sync;
  // segment line per pin, pad order
  logic [7:0] seg_by_pin;
  // enable bits remapped to pad order
  logic [7:0] seg_en_by_pin;
  // pad drive computed each cycle
  lsp_pad_t pad_next;
  // pin value seen by software
  logic [7:0] pin_value;

  initial begin
    if (PIN_COUNT != 8) begin
      $error("lsp_port: only an eight-pin port is supported");
    end
  end

  // pad inputs come from outside the clock domain
  lsp_sync #(
    .WIDTH(8)
  ) u_sync (
    .clk(clk),
    .reset(reset),
    .clk_en(clk_en),
    .async_in(schmitt_input),
    .sync_out(pin_sync)
  );

  // pad mapping: enable register bit k names segment 32+k
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_map
      if (g < 4) begin : g_low
        // pin g carries segment 32+g
        assign seg_by_pin[g] = lcd_segment_in[g];
        assign seg_en_by_pin[g] = segment_enable_upper_reg[g];
      end else begin : g_high
        // pin g carries segment 39-(g-4) = enable bit 11-g
        assign seg_by_pin[g] = lcd_segment_in[11-g];
        assign seg_en_by_pin[g] = segment_enable_upper_reg[11-g];
      end
    end
  endgenerate

  // pad ownership: segment wins over direction and latch
  always_comb begin
    pad_next.seg_sel = seg_en_by_pin;
    pad_next.oe = ~port_direction_reg & ~seg_en_by_pin;
    pad_next.dout = port_output_latch_reg & pad_next.oe;
  end

  // a pin owned by a segment reads as zero, io is not available there
  assign pin_value = pin_sync & ~seg_en_by_pin;

  // register writes; reset leaves every pin an input
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      port_output_latch_reg <= LSP_RESET_LATCH;
      port_direction_reg <= LSP_RESET_DIR;
      segment_enable_upper_reg <= LSP_RESET_SEG;
    end else if (clk_en && bus_req.wr) begin
      unique case (bus_req.addr)
        // writing the pin value register writes the latch
        LSP_ADDR_PIN_VALUE: port_output_latch_reg <= bus_req.wdata;
        LSP_ADDR_OUT_LATCH: port_output_latch_reg <= bus_req.wdata;
        LSP_ADDR_DIRECTION: port_direction_reg <= bus_req.wdata;
        LSP_ADDR_SEG_ENABLE: segment_enable_upper_reg <= bus_req.wdata;
      endcase
    end
  end

  // read data one cycle after the strobe, zero after an enabled cycle without one, held while clock enable is low
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      bus_rdata <= 8'h00;
    end else if (clk_en) begin
      if (bus_req.rd) begin
        unique case (bus_req.addr)
          LSP_ADDR_PIN_VALUE: bus_rdata <= pin_value;
          LSP_ADDR_OUT_LATCH: bus_rdata <= port_output_latch_reg;
          LSP_ADDR_DIRECTION: bus_rdata <= port_direction_reg;
          LSP_ADDR_SEG_ENABLE: bus_rdata <= segment_enable_upper_reg;
        endcase
      end else begin
        bus_rdata <= 8'h00;
      end
    end
  end

  // pad outputs registered; one cycle after a register write they follow
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      digital_output <= 8'h00;
      digital_output_en <= 8'h00;
      analog_segment_output <= 8'h00;
      analog_segment_sel <= 8'h00;
    end else if (clk_en) begin
      digital_output <= pad_next.dout;
      digital_output_en <= pad_next.oe;
      // segment level only passed while the segment owns the pad
      analog_segment_output <= seg_by_pin & pad_next.seg_sel;
      analog_segment_sel <= pad_next.seg_sel;
    end
  end

  // assertions
  a_seg_blocks_drive: assert property (@(posedge clk) disable iff (reset)
    (analog_segment_sel & digital_output_en) == 8'h00)
    else $error("pad driven digitally while segment owns it");

  a_reset_all_input: assert property (@(posedge clk)
    $fell(reset) |-> digital_output_en == 8'h00 && analog_segment_sel == 8'h00)
    else $error("pad not an input after reset");

  a_out_enable_dir: assert property (@(posedge clk) disable iff (reset)
    clk_en |=> digital_output_en == (~$past(port_direction_reg) & ~$past(seg_en_by_pin)))
    else $error("output enable does not follow direction");

  a_out_data_latch: assert property (@(posedge clk) disable iff (reset)
    clk_en |=> (digital_output & digital_output_en) ==
      ($past(port_output_latch_reg) & digital_output_en))
    else $error("driven pad does not carry latch value");

  a_low_map_order: assert property (@(posedge clk) disable iff (reset)
    clk_en |=> analog_segment_sel[3:0] == $past(segment_enable_upper_reg[3:0]))
    else $error("low pads not mapped to segments 32..35");

  a_high_map_rev: assert property (@(posedge clk) disable iff (reset)
    clk_en |=> analog_segment_sel[7:4] == {$past(segment_enable_upper_reg[4]),
      $past(segment_enable_upper_reg[5]), $past(segment_enable_upper_reg[6]),
      $past(segment_enable_upper_reg[7])})
    else $error("high pads not mapped to segments 39..36");

  sequence s_read_pin;
    clk_en && bus_req.rd && bus_req.addr == LSP_ADDR_PIN_VALUE;
  endsequence

  a_read_pin_value: assert property (@(posedge clk) disable iff (reset)
    s_read_pin |=> bus_rdata == ($past(pin_sync) & ~$past(seg_en_by_pin)))
    else $error("pin value read does not show synchronised pad");

  a_io_only_free: assert property (@(posedge clk) disable iff (reset)
    s_read_pin ##1 1'b1 |-> (bus_rdata & $past(seg_en_by_pin)) == 8'h00)
    else $error("segment pad visible as io input");

  a_dir_write: assert property (@(posedge clk) disable iff (reset)
    clk_en && bus_req.wr && bus_req.addr == LSP_ADDR_DIRECTION
      |=> port_direction_reg == $past(bus_req.wdata))
    else $error("direction write lost");

  // a write taken on either alias of the output latch
  sequence s_write_latch;
    clk_en && bus_req.wr &&
      (bus_req.addr == LSP_ADDR_OUT_LATCH || bus_req.addr == LSP_ADDR_PIN_VALUE);
  endsequence

  // a write taken on the segment enable register
  sequence s_write_seg;
    clk_en && bus_req.wr && bus_req.addr == LSP_ADDR_SEG_ENABLE;
  endsequence

  // a read taken on the output latch
  sequence s_read_latch;
    clk_en && bus_req.rd && bus_req.addr == LSP_ADDR_OUT_LATCH;
  endsequence

  // both latch aliases land in the one latch register
  a_latch_write: assert property (@(posedge clk) disable iff (reset)
    s_write_latch |=> port_output_latch_reg == $past(bus_req.wdata))
    else $error("latch write lost");

  // latch reads back what software last stored
  a_read_latch: assert property (@(posedge clk) disable iff (reset)
    s_read_latch |=> bus_rdata == $past(port_output_latch_reg))
    else $error("latch read back wrong");

  // segment enable lands; the pads follow one cycle later
  a_seg_write: assert property (@(posedge clk) disable iff (reset)
    s_write_seg |=> segment_enable_upper_reg == $past(bus_req.wdata))
    else $error("segment enable write lost");

  // a segment pad never carries latch data on its digital output
  a_seg_no_data: assert property (@(posedge clk) disable iff (reset)
    (digital_output & analog_segment_sel) == 8'h00)
    else $error("latch data on a segment pad");

  // segment level only where a segment owns the pad
  a_seg_level_sel: assert property (@(posedge clk) disable iff (reset)
    (analog_segment_output & ~analog_segment_sel) == 8'h00)
    else $error("segment level on a free pad");

  // a pin set as input is never driven by the port
  a_in_released: assert property (@(posedge clk) disable iff (reset)
    clk_en |=> (digital_output_en & $past(port_direction_reg)) == 8'h00)
    else $error("input pin driven");

  // read data stands one enabled cycle, zero after an enabled cycle with no read taken
  a_rdata_idle: assert property (@(posedge clk) disable iff (reset)
    clk_en && !bus_req.rd |=> bus_rdata == 8'h00)
    else $error("read data outside its cycle");

  // frozen clock enable: pads hold, so a paused bus never glitches a pin
  a_freeze_hold: assert property (@(posedge clk) disable iff (reset)
    !clk_en |=> $stable(digital_output_en) && $stable(digital_output))
    else $error("pad outputs moved while frozen");
endmodule : lsp_port

// >>> test/lsp_pads.sv
// pad model for the shared port: loopback of driven pins
`timescale 1ns/1ns
module lsp_pads (
  input wire logic [7:0] dout,
  input wire logic [7:0] oe,
  input wire logic [7:0] ext,
  output logic [7:0] pin
);
  // driven pins echo the device, released pins show the outside level
  assign pin = (dout & oe) | (ext & ~oe);
endmodule : lsp_pads

// >>> test/lsp_port_tb.sv
// self-checking bench for the lcd-shared io port
`timescale 1ns/1ns
module lsp_port_tb;
  import lsp_pkg::*;
  logic clk = 1'b0; // 20 MHz
  logic reset = 1'b1; // held 10 cycles
  logic clk_en = 1'b1; // low only in the freeze test
  lsp_bus_req_t req = '0; // register bus
  logic [7:0] ext = 8'h00; // outside pad level
  logic [7:0] lcd = 8'h00; // segment driver levels
  logic [7:0] rdata, pin, dout, oe, aout, asel;
  int n_fail = 0;
  int total_checks = 0;
  lsp_pads pads_u (.dout(dout), .oe(oe), .ext(ext), .pin(pin));
  lsp_port dut_u (.clk(clk), .reset(reset), .clk_en(clk_en), .bus_req(req),
    .bus_rdata(rdata), .schmitt_input(pin), .lcd_segment_in(lcd),
    .digital_output(dout), .digital_output_en(oe),
    .analog_segment_output(aout), .analog_segment_sel(asel));
  // clock
  initial begin
    forever #25 clk = ~clk;
  end
  // one compare for every byte-wide result
  task chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk
  // one-cycle write strobe
  task wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk) req <= '{a, d, 1'b1, 1'b0};
    @(posedge clk) req <= '0;
  endtask : wr
  // one-cycle read strobe, data looked at only in the following cycle
  task rd(input logic [1:0] a, input logic [7:0] exp, input string m);
    @(posedge clk) req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk) req <= '0;
    @(negedge clk) chk(rdata, exp, m);
  endtask : rd
  // reset values of registers and pads
  task t_reset;
    rd(LSP_ADDR_OUT_LATCH, 8'h00, "latch reset");
    rd(LSP_ADDR_DIRECTION, 8'hff, "dir reset");
    rd(LSP_ADDR_SEG_ENABLE, 8'h00, "seg reset");
    chk(oe | asel, 8'h00, "pads after reset");
    $display("test reset done");
  endtask : t_reset
  // outputs follow the latch, loopback reads back
  task t_drive;
    wr(LSP_ADDR_DIRECTION, 8'h00);
    wr(LSP_ADDR_OUT_LATCH, 8'ha5);
    repeat (2) @(posedge clk);
    @(negedge clk) chk(oe, 8'hff, "oe");
    chk(dout, 8'ha5, "dout");
    rd(LSP_ADDR_PIN_VALUE, 8'ha5, "loopback");
    wr(LSP_ADDR_PIN_VALUE, 8'h5a);
    rd(LSP_ADDR_OUT_LATCH, 8'h5a, "pin write");
    $display("test drive done");
  endtask : t_drive
  // inputs read the schmitt level after the synchroniser
  task t_input;
    wr(LSP_ADDR_DIRECTION, 8'hff);
    @(posedge clk) ext <= 8'h3c;
    repeat (3) @(posedge clk);
    rd(LSP_ADDR_PIN_VALUE, 8'h3c, "input");
    $display("test input done");
  endtask : t_input
  // segments 32,36,37 own pins 0,7,6; direction ignored there
  task t_segment;
    wr(LSP_ADDR_DIRECTION, 8'h00);
    wr(LSP_ADDR_OUT_LATCH, 8'ha5);
    wr(LSP_ADDR_SEG_ENABLE, 8'h31);
    @(posedge clk) lcd <= 8'h21;
    ext <= 8'hff;
    repeat (3) @(posedge clk);
    @(negedge clk) chk(asel, 8'hc1, "seg select");
    chk(aout, 8'h41, "seg level");
    chk(oe, 8'h3e, "oe off on seg");
    chk(dout, 8'h24, "dout masked");
    rd(LSP_ADDR_PIN_VALUE, 8'h24, "seg pins read 0");
    $display("test segment done");
  endtask : t_segment
  // a write while clock enable is low must be ignored
  task t_freeze;
    @(posedge clk) clk_en <= 1'b0;
    wr(LSP_ADDR_OUT_LATCH, 8'h0f);
    @(posedge clk) clk_en <= 1'b1;
    rd(LSP_ADDR_OUT_LATCH, 8'ha5, "frozen write ignored");
    $display("test freeze done");
  endtask : t_freeze
  // reset in mid-run brings every pin back to an input
  task t_reset_mid;
    @(posedge clk) reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    rd(LSP_ADDR_DIRECTION, 8'hff, "dir after reset");
    rd(LSP_ADDR_SEG_ENABLE, 8'h00, "seg after reset");
    chk(oe | asel, 8'h00, "pads after mid reset");
    $display("test mid reset done");
  endtask : t_reset_mid
  // verdict, the single end of the run
  task results;
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : results
  // main sequence
  initial begin
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    t_reset();
    t_drive();
    t_input();
    t_segment();
    t_freeze();
    t_reset_mid();
    results();
  end
  // watchdog, far beyond the sixty-odd cycles of the tests
  initial begin
    #(50 * 2000);
    n_fail++;
    results();
  end
endmodule : lsp_port_tb
